//--- core/cmu_top.sv

`timescale 1ns/1ns
`default_nettype none

module cmu_top (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [cmu_pkg::PIX_W-1:0]   in_red,
    input  wire logic [cmu_pkg::PIX_W-1:0]   in_green,
    input  wire logic [cmu_pkg::PIX_W-1:0]   in_blue,
    output logic                             out_clk,
    output logic      [cmu_pkg::PIX_W-1:0]   out_red,
    output logic      [cmu_pkg::PIX_W-1:0]   out_green,
    output logic      [cmu_pkg::PIX_W-1:0]   out_blue,
    output logic                             out_ddr,
    output logic                             out_valid
);

    logic signed [cmu_pkg::COEF_W-1:0] coef_reg [cmu_pkg::NUM_COEF];
    logic        [cmu_pkg::EXP_W-1:0]  exp_reg;
    cmu_pkg::cmu_fmt_type              fmt_reg;
    logic        [cmu_pkg::WID_W-1:0]  wid_reg;
    logic        [2:0]                 sets_reg;
    logic                              chroma_ph_reg;
    logic        [cmu_pkg::PIX_W-1:0]  in_reg [3];
    logic        [cmu_pkg::PIX_W-1:0]  res [3];
    logic        [cmu_pkg::PIX_W-1:0]  raw [3];
    logic        [3:0]                 shift;
    logic                              wr_en;
    logic                              rd_setup;
    logic                              coef_hit;
    logic                              ctrl_hit;
    logic                              stat_hit;
    logic        [3:0]                 coef_idx;
    logic        [31:0]                rd_next;
    logic        [31:0]                ctrl_word;
    logic        [31:0]                stat_word;
    logic        [cmu_pkg::PIX_W-1:0]  chroma;

    ////////////////////////////////////////////////////////////////////
    // Register decode
    assign coef_idx = paddr[5:2];
    assign coef_hit = (paddr[1:0] == 2'h0)
                   && (paddr < (cmu_pkg::COEF_BASE_ADDR + 8'h30));
    assign ctrl_hit = (paddr == cmu_pkg::CTRL_ADDR);
    assign stat_hit = (paddr == cmu_pkg::STAT_ADDR);
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !(coef_hit || ctrl_hit || stat_hit);

    assign ctrl_word = {24'h000000, wid_reg, fmt_reg, exp_reg};
    assign stat_word = {28'h0000000, sets_reg, out_valid};

    always_comb begin
        rd_next = 32'h00000000;
        if (coef_hit) begin
            rd_next = {{19{coef_reg[coef_idx][12]}}, coef_reg[coef_idx]};
        end else if (ctrl_hit) begin
            rd_next = ctrl_word;
        end else if (stat_hit) begin
            rd_next = stat_word;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Coefficient and offset registers
    genvar i;
    generate
        for (i = 0; i < cmu_pkg::NUM_COEF; i++) begin : g_coef
            localparam logic [12:0] RST_VAL = ((i % 5) == 0 && i < 11)
                ? cmu_pkg::COEF_UNITY_RST : cmu_pkg::COEF_ZERO_RST;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    coef_reg[i] <= RST_VAL;
                end else if (wr_en && coef_hit && coef_idx == 4'(i)) begin
                    coef_reg[i] <= pwdata[cmu_pkg::COEF_W-1:0];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Control register, one field per process
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exp_reg <= cmu_pkg::EXP_RST;
        end else if (wr_en && ctrl_hit) begin
            exp_reg <= pwdata[cmu_pkg::CTRL_EXP_LSB +: cmu_pkg::EXP_W];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fmt_reg <= cmu_pkg::FMT_RST;
        end else if (wr_en && ctrl_hit) begin
            fmt_reg <= cmu_pkg::cmu_fmt_type'(
                pwdata[cmu_pkg::CTRL_FMT_LSB +: 2]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wid_reg <= cmu_pkg::WID_RST;
        end else if (wr_en && ctrl_hit) begin
            wid_reg <= pwdata[cmu_pkg::CTRL_WID_LSB +: cmu_pkg::WID_W];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            prdata <= rd_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Input alignment, MSB-justified to 12 bits
    always_comb begin
        if (wid_reg < cmu_pkg::WID_MIN) begin
            shift = cmu_pkg::WID_MAX - cmu_pkg::WID_MIN;
        end else if (wid_reg > cmu_pkg::WID_MAX) begin
            shift = 4'h0;
        end else begin
            shift = cmu_pkg::WID_MAX - wid_reg;
        end
    end

    assign raw[0] = in_red;
    assign raw[1] = in_green;
    assign raw[2] = in_blue;

    generate
        for (i = 0; i < 3; i++) begin : g_in
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    in_reg[i] <= '0;
                end else begin
                    in_reg[i] <= raw[i] << shift;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Three matrix rows
    generate
        for (i = 0; i < 3; i++) begin : g_row
            cmu_coef_if cf ();
            assign cf.coeff[0] = coef_reg[i*4];
            assign cf.coeff[1] = coef_reg[i*4 + 1];
            assign cf.coeff[2] = coef_reg[i*4 + 2];
            assign cf.offset   = coef_reg[i*4 + 3];
            assign cf.exponent = exp_reg;
            cmu_channel u_chan (
                .pclk    (pclk),
                .presetn (presetn),
                .cf      (cf.snk),
                .in0     (in_reg[0]),
                .in1     (in_reg[1]),
                .in2     (in_reg[2]),
                .result  (res[i])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Output format stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chroma_ph_reg <= 1'b0;
        end else if (fmt_reg == cmu_pkg::FMT_422
                     || fmt_reg == cmu_pkg::FMT_422_DDR) begin
            chroma_ph_reg <= !chroma_ph_reg;
        end else begin
            chroma_ph_reg <= 1'b0;
        end
    end

    // Cb (row 2) on even pixels, Cr (row 0) on odd pixels
    assign chroma = chroma_ph_reg ? res[0] : res[2];

    // Red port, rising-edge half in double-rate formats
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_red <= '0;
        end else begin
            unique case (fmt_reg)
                cmu_pkg::FMT_444: begin
                    out_red <= res[0];
                end
                cmu_pkg::FMT_422: begin
                    out_red <= chroma;
                end
                cmu_pkg::FMT_444_DDR: begin
                    out_red <= {res[0][11:4], res[1][11:8]};
                end
                cmu_pkg::FMT_422_DDR: begin
                    out_red <= chroma;
                end
            endcase
        end
    end

    // Green port, falling-edge half in double-rate formats
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_green <= '0;
        end else begin
            unique case (fmt_reg)
                cmu_pkg::FMT_444: begin
                    out_green <= res[1];
                end
                cmu_pkg::FMT_422: begin
                    out_green <= res[1];
                end
                cmu_pkg::FMT_444_DDR: begin
                    out_green <= {res[1][7:4], res[2][11:4]};
                end
                cmu_pkg::FMT_422_DDR: begin
                    out_green <= res[1];
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_blue <= '0;
        end else begin
            unique case (fmt_reg)
                cmu_pkg::FMT_444: begin
                    out_blue <= res[2];
                end
                cmu_pkg::FMT_422: begin
                    out_blue <= '0;
                end
                cmu_pkg::FMT_444_DDR: begin
                    out_blue <= '0;
                end
                cmu_pkg::FMT_422_DDR: begin
                    out_blue <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ddr <= 1'b0;
        end else begin
            unique case (fmt_reg)
                cmu_pkg::FMT_444: begin
                    out_ddr <= 1'b0;
                end
                cmu_pkg::FMT_422: begin
                    out_ddr <= 1'b0;
                end
                cmu_pkg::FMT_444_DDR: begin
                    out_ddr <= 1'b1;
                end
                cmu_pkg::FMT_422_DDR: begin
                    out_ddr <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output clock, rising mid-cycle of the data
    assign out_clk = !pclk;

    ////////////////////////////////////////////////////////////////////
    // Pipeline fill tracking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sets_reg <= 3'h0;
        end else if (sets_reg != cmu_pkg::SETS_DONE) begin
            sets_reg <= sets_reg + 3'h1;
        end
    end

    assign out_valid = (sets_reg == cmu_pkg::SETS_DONE);

endmodule : cmu_top

`default_nettype wire

//--- core/cmu_pkg.sv
`default_nettype none

package cmu_pkg;

    localparam int COEF_W    = 13;
    localparam int FRAC_W    = 12;
    localparam int PIX_W     = 12;
    localparam int EXP_W     = 2;
    localparam int WID_W     = 4;
    localparam int NUM_COEF  = 12;
    localparam int PIPE_SETS = 6;

    // Register byte offsets: row r, term k at (r*4 + k) * 4
    localparam logic [7:0] COEF_BASE_ADDR = 8'h00;
    localparam logic [7:0] CTRL_ADDR      = 8'h30;
    localparam logic [7:0] STAT_ADDR      = 8'h34;

    // Control field positions
    localparam int CTRL_EXP_LSB = 0;
    localparam int CTRL_FMT_LSB = 2;
    localparam int CTRL_WID_LSB = 4;

    // Values after reset: unity matrix, exponent 1, 12-bit input
    localparam logic [12:0] COEF_UNITY_RST = 13'h0800;
    localparam logic [12:0] COEF_ZERO_RST  = 13'h0000;
    localparam logic [1:0]  EXP_RST        = 2'h1;
    localparam logic [3:0]  WID_RST        = 4'hC;
    localparam logic [3:0]  WID_MIN        = 4'h8;
    localparam logic [3:0]  WID_MAX        = 4'hC;
    localparam logic [2:0]  SETS_DONE      = 3'h6;

    typedef enum logic [1:0] {
        FMT_444     = 2'b00,
        FMT_422     = 2'b01,
        FMT_444_DDR = 2'b10,
        FMT_422_DDR = 2'b11
    } cmu_fmt_type;

    localparam cmu_fmt_type FMT_RST = FMT_444;

endpackage : cmu_pkg

`default_nettype wire

//--- core/cmu_coef_if.sv
`timescale 1ns/1ns
`default_nettype none

interface cmu_coef_if;
    logic signed [cmu_pkg::COEF_W-1:0] coeff [3];
    logic signed [cmu_pkg::COEF_W-1:0] offset;
    logic        [cmu_pkg::EXP_W-1:0]  exponent;

    modport src (
        output coeff,
        output offset,
        output exponent
    );
    modport snk (
        input coeff,
        input offset,
        input exponent
    );
endinterface : cmu_coef_if

`default_nettype wire

//--- core/cmu_channel.sv
`timescale 1ns/1ns
`default_nettype none

module cmu_channel (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    cmu_coef_if.snk                         cf,
    input  wire logic [cmu_pkg::PIX_W-1:0]  in0,
    input  wire logic [cmu_pkg::PIX_W-1:0]  in1,
    input  wire logic [cmu_pkg::PIX_W-1:0]  in2,
    output logic      [cmu_pkg::PIX_W-1:0]  result
);

    logic signed [25:0] prod_reg [3];
    logic signed [29:0] acc_reg;
    logic signed [29:0] scl_reg;
    logic signed [29:0] sum_next;
    logic signed [29:0] int_next;
    logic        [12:0] ops [3];

    assign ops[0] = {1'b0, in0};
    assign ops[1] = {1'b0, in1};
    assign ops[2] = {1'b0, in2};

    ////////////////////////////////////////////////////////////////////
    // Stage 1: three products
    genvar k;
    generate
        for (k = 0; k < 3; k++) begin : g_mul
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    prod_reg[k] <= '0;
                end else begin
                    prod_reg[k] <= cf.coeff[k] * $signed(ops[k]);
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Stage 2: sum plus row offset
    always_comb begin
        sum_next = 30'(prod_reg[0]) + 30'(prod_reg[1])
                 + 30'(prod_reg[2]);
        sum_next = sum_next
                 + (30'(cf.offset) <<< cmu_pkg::FRAC_W);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg <= '0;
        end else begin
            acc_reg <= sum_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Stage 3: common power-of-two scale
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_reg <= '0;
        end else begin
            scl_reg <= acc_reg <<< cf.exponent;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Stage 4: drop fraction, saturate
    assign int_next = scl_reg >>> cmu_pkg::FRAC_W;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result <= '0;
        end else if (int_next < 30'sd0) begin
            result <= '0;
        end else if (int_next > 30'sd4095) begin
            result <= '1;
        end else begin
            result <= int_next[cmu_pkg::PIX_W-1:0];
        end
    end

endmodule : cmu_channel

`default_nettype wire

//--- testbench/cmu_assertions.sv
`timescale 1ns/1ns
`default_nettype none

module cmu_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        out_clk,
    input wire logic        out_valid
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic acc;
    logic mapped;
    assign acc = psel && penable;
    assign mapped = paddr <= cmu_pkg::STAT_ADDR && paddr[1:0] == 2'h0;

    ////////////////////////////////////////////////////////////////////////
    pready_on_a: assert property (acc |-> pready)
        else $error("pready low in access phase");
    bad_addr_a: assert property (acc && !mapped |-> pslverr)
        else $error("unmapped access not flagged");
    bad_rd_a: assert property (acc && !mapped && !pwrite
        |-> prdata == 32'h0) else $error("unmapped read data not zero");
    good_addr_a: assert property (acc && mapped |-> !pslverr)
        else $error("mapped access flagged");
    err_idle_a: assert property (!acc |-> !pslverr)
        else $error("error outside access phase");
    rd_hold_a: assert property (acc |=> $stable(prdata))
        else $error("read data moved after access");
    clk_mid_a: assert property (out_clk)
        else $error("output clock low before pclk rise");
    clk_low_a: assert property (@(negedge pclk) !out_clk)
        else $error("output clock high before pclk fall");
    valid_keep_a: assert property (out_valid |=> out_valid)
        else $error("valid dropped");
    valid_time_a: assert property ($rose(presetn)
        |-> !out_valid [*6] ##1 out_valid) else $error("valid timing");
endmodule : cmu_assertions

`default_nettype wire

//--- testbench/cmu_scaler_model.sv
`timescale 1ns/1ns
`default_nettype none

module cmu_scaler_model (
    input  wire logic        out_clk,
    input  wire logic        out_valid,
    input  wire logic [11:0] out_red,
    input  wire logic [11:0] out_green,
    output logic      [11:0] cap_rise,
    output logic      [11:0] cap_fall
);
    // Latch mid-cycle, skip unflushed sets
    always @(posedge out_clk)
        if (out_valid) cap_rise <= out_red;
    // Second half on the falling edge
    always @(negedge out_clk)
        if (out_valid) cap_fall <= out_green;
endmodule : cmu_scaler_model

`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, out_clk, out_ddr, out_valid, err;
    logic [11:0] in_red = 0, in_green = 0, in_blue = 0, cap_rise, cap_fall;
    logic [11:0] out_red, out_green, out_blue;
    logic [35:0] q[$];
    int          fail_count = 0, n_tests = 0, cf[12], mexp, mfmt, mwid;

    always #4 pclk = ~pclk;

    cmu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .in_red(in_red), .in_green(in_green), .in_blue(in_blue),
        .out_clk(out_clk), .out_red(out_red), .out_green(out_green),
        .out_blue(out_blue), .out_ddr(out_ddr), .out_valid(out_valid));
    cmu_scaler_model rx (.out_clk(out_clk), .out_valid(out_valid),
        .out_red(out_red), .out_green(out_green),
        .cap_rise(cap_rise), .cap_fall(cap_fall));

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] ex);
        n_tests++;
        if (got !== ex) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, ex);
        end
    endtask : chk_reg

    task automatic chk_pix(input logic [11:0] got, input logic [11:0] ex);
        chk_reg({20'h0, got}, {20'h0, ex});
    endtask : chk_pix

    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'(d);
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Reference pixel for one matrix row
    function automatic logic [11:0] px(int r, logic [35:0] v);
        longint s;
        s = longint'(cf[r*4+3]) * 4096;
        for (int k = 0; k < 3; k++)
            s += cf[r*4+k] * (longint'(v[35-12*k -: 12]) << (12 - mwid));
        s = (s <<< mexp) >>> 12;
        return s < 0 ? 12'h000 : s > 4095 ? 12'hFFF : 12'(s);
    endfunction : px

    task automatic cfg(input int e, input int f, input int w);
        mexp = e;
        mfmt = f;
        mwid = w;
        for (int i = 0; i < 12; i++) begin
            cf[i] = $signed(13'($urandom));
            apb(1'b1, 8'(i * 4), cf[i]);
            apb(1'b0, 8'(i * 4), 0);
            chk_reg(rd, 32'(cf[i]));
        end
        apb(1'b1, cmu_pkg::CTRL_ADDR, w * 16 + f * 4 + e);
    endtask : cfg

    task automatic stream(input int n);
        logic [35:0] v;
        logic [11:0] m, e0, e1, e2, ec, rh, fh, pr, pg;
        int ix;
        ix = 0;
        m = 12'((1 << mwid) - 1);
        q.delete();
        repeat (n + 7) begin
            @(posedge pclk);
            v = {12'($urandom) & m, 12'($urandom) & m, 12'($urandom) & m};
            in_red <= v[35:24];
            in_green <= v[23:12];
            in_blue <= v[11:0];
            q.push_back(v);
            #1;
            // Pixel driven six edges ago stands on the outputs now
            if (q.size() == cmu_pkg::PIPE_SETS + 1) begin
                v = q.pop_front();
                e0 = px(0, v);
                e1 = px(1, v);
                e2 = px(2, v);
                // Chroma starts on Cb right after the format write
                ec = ix[0] ? e0 : e2;
                chk_pix(12'(out_ddr), 12'(mfmt >> 1));
                if (mfmt == 0) begin
                    chk_pix(out_red, e0);
                    chk_pix(out_green, e1);
                    chk_pix(out_blue, e2);
                end else if (mfmt == 1) begin
                    chk_pix(out_red, ec);
                    chk_pix(out_green, e1);
                end else begin
                    rh = (mfmt == 2) ? {e0[11:4], e1[11:8]} : ec;
                    fh = (mfmt == 2) ? {e1[7:4], e2[11:4]} : e1;
                    chk_pix(out_red, rh);
                    chk_pix(out_green, fh);
                    if (ix > 0) chk_pix(cap_rise, pr);
                    if (ix > 0) chk_pix(cap_fall, pg);
                    pr = rh;
                    pg = fh;
                end
                ix++;
            end
        end
    endtask : stream

    initial begin
        #200000;
        fail_count++;
        conclude();
    end

    initial begin
        void'($urandom(32'h4c785076));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 0);
        chk_reg(rd, 32'h0000_0800);
        apb(1'b0, 8'h04, 0);
        chk_reg(rd, 32'h0000_0000);
        apb(1'b0, cmu_pkg::CTRL_ADDR, 0);
        chk_reg(rd, 32'h0000_00C1);
        apb(1'b1, cmu_pkg::STAT_ADDR, 0);
        apb(1'b0, cmu_pkg::STAT_ADDR, 0);
        chk_reg(rd, 32'h0000_000D);
        apb(1'b0, 8'h38, 0);
        chk_reg({31'h0, err}, 32'h1);
        chk_reg(rd, 32'h0);
        foreach (cf[i]) cf[i] = (i % 5 == 0) ? 2048 : 0;
        mexp = 1;
        mfmt = 0;
        mwid = 12;
        stream(12);
        $display("test reset matrix done");
        for (int t = 0; t < 7; t++) begin
            cfg(t < 4 ? t : 1, t < 4 ? 0 : t - 3, t == 2 ? 8 : 12);
            stream(16);
            $display("test %0d done", t);
        end
        conclude();
    end
endmodule : tb

bind cmu_top cmu_assertions chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .out_clk(out_clk), .out_valid(out_valid));

`default_nettype wire
